/* design/sensor_output_sync_framing_defs.svh */
`ifndef SENSOR_OUTPUT_SYNC_FRAMING_DEFS_SVH
`define SENSOR_OUTPUT_SYNC_FRAMING_DEFS_SVH

// Register addresses as seen on the serial port
`define A_TRSV_A    9'h050
`define A_TRSV_B    9'h051
`define A_TRSV_C    9'h060
`define A_TRSV_D    9'h061
`define A_PWR       9'h070
`define A_BLK       9'h080
`define A_GEN       9'h081
`define A_TRAIN     9'h082
`define A_SW0       9'h083
`define A_FSYNC     9'h084
`define A_BID       9'h085
`define A_VID       9'h086
`define A_TID       9'h087
`define A_ERR_A     9'h088
`define A_ERR_B     9'h089
`define A_ERR_C     9'h08a
`define A_ERR_D     9'h08b
`define A_DRSV_A    9'h08c
`define A_DRSV_B    9'h08d

// Reset values
`define RST_PWR     3'h0
`define RST_BLK     16'h4008
`define RST_GEN     16'hc001
`define RST_TRAIN   10'h3a6
`define RST_SW0     16'h002a
`define RST_FSYNC   7'h2a
`define RST_BID     10'h035
`define RST_VID     10'h059
`define RST_TID     10'h3a6
`define RST_DRSV_B  16'hffff

// Field positions
`define F_CLK_PWD_N   0
`define F_SYNC_PWD_N  1
`define F_DATA_PWD_N  2
`define F_TGT_HI      7
`define F_SAMP_HI     10
`define F_SAMP_LO     8
`define F_CRC_SEED    15
`define F_AUTO_CAL    0
`define F_OFS_HI      9
`define F_OFS_LO      1
`define F_OFS_DEC     10
`define F_NARROW      13

// Serial frame: 9 address bits, write flag, 16 data bits
`define SPI_HDR_BITS  5'd10
`define SPI_ALL_BITS  5'd26
`define NARROW_DELAY  4
`define CRC_POLY      10'h233

`endif

/* design/sensor_output_sync_framing_pkg.sv */
package sensor_output_sync_framing_pkg;
  localparam int NCH = 4;

  typedef enum logic [1:0] {
    SPI_IDLE  = 2'b00,
    SPI_SHIFT = 2'b01,
    SPI_DONE  = 2'b11
  } spi_ph_t;

  typedef struct packed {
    logic                valid;
    logic                black;
    logic                sof;
    logic                sol;
    logic                eof;
    logic                eol;
    logic [NCH-1:0][9:0] pix;
  } pix_in_t;

  typedef struct packed {
    logic [NCH-1:0][9:0] data;
    logic [9:0]          sync;
  } lanes_t;

  typedef struct packed {
    logic [1:0]           sclk_s;
    logic [1:0]           ss_s;
    logic [1:0]           mosi_s;
    logic                 sclk_p;
    logic                 ss_p;
    spi_ph_t              ph;
    logic [4:0]           bcnt;
    logic [25:0]          sh;
    logic [15:0]          rd;
    logic                 miso;
    logic [2:0]           pwr;
    logic [15:0]          blk;
    logic [15:0]          gen;
    logic [15:0]          sw0;
    logic [9:0]           train;
    logic [6:0]           fsync;
    logic [9:0]           bid;
    logic [9:0]           vid;
    logic [9:0]           tid;
    logic [NCH-1:0]       err;
    logic [NCH-1:0]       done;
    logic [NCH-1:0]       bline;
    logic [NCH-1:0][16:0] acc;
    logic [NCH-1:0][7:0]  cnt;
    logic [NCH-1:0][10:0] ofs;
    logic [NCH-1:0][9:0]  crc;
    logic [3:0][9:0]      dl;
    lanes_t               out;
    logic [2:0]           en;
  } st_t;
endpackage : sensor_output_sync_framing_pkg

/* design/sensor_output_sync_framing.sv */
// Functional notes
// - Clock, sync and data lanes run only while their low-active bit is 1.
// - Eight-bit target field is the black level the output is pulled to.
// - Black average uses two to the power of the sample field samples.
// - Line CRC starts from all zeros, or all ones when seed bit set.
// - Manual black offset applies only while auto calibration is off.
// - Manual offset is added when direction bit is 0, subtracted when 1.
// - Word width bit picks 10 or 8 bits; 8-bit delays sync IDs 4 cycles.
// - Idle data lanes carry the programmable training word, reset 0x3a6.
// - Frame sync word is three top status bits plus seven programmed bits.
// - Sync word top bit frame versus line, next start, next end.
// - Black pixel ID code goes on the sync lane for black data.
// - Valid pixel ID code goes on the sync lane for image data.
// - Training ID code goes on the sync lane during training words.
// - Per-channel flag set when too few black samples reached calibration.
`timescale 1ns/100ps
`include "sensor_output_sync_framing_defs.svh"

module sensor_output_sync_framing
  import sensor_output_sync_framing_pkg::*;
(
  input  wire logic    sys_clk_i,
  input  wire logic    rst_i,
  input  wire logic    spi_sclk_i,
  input  wire logic    spi_ss_n_i,
  input  wire logic    spi_mosi_i,
  output logic         spi_miso_o,
  input  wire pix_in_t pix_i,
  output lanes_t       lanes_o,
  output logic         clk_lane_en_o,
  output logic         sync_lane_en_o,
  output logic         data_lane_en_o
);

  st_t q;
  st_t next_q;

  function automatic logic [9:0] crc_step(input logic [9:0] c,
                                          input logic [9:0] d);
    logic [9:0] r;
    logic       fb;
    r = c;
    for (int i = 9; i >= 0; i--) begin
      fb = r[9] ^ d[i];
      r  = {r[8:0], 1'b0} ^ (fb ? `CRC_POLY : 10'h000);
    end
    return r;
  endfunction : crc_step

  function automatic logic [9:0] clamp(input logic signed [11:0] v);
    if (v < 12'sd0) begin
      return 10'h000;
    end else if (v > 12'sd1023) begin
      return 10'h3ff;
    end
    return v[9:0];
  endfunction : clamp

  function automatic logic [15:0] reg_rd(input st_t s,
                                         input logic [8:0] a);
    if (a == `A_PWR) begin
      return {13'h0000, s.pwr};
    end else if (a == `A_BLK) begin
      return s.blk;
    end else if (a == `A_GEN) begin
      return s.gen;
    end else if (a == `A_TRAIN) begin
      return {6'h00, s.train};
    end else if (a == `A_SW0) begin
      return s.sw0;
    end else if (a == `A_FSYNC) begin
      return {9'h000, s.fsync};
    end else if (a == `A_BID) begin
      return {6'h00, s.bid};
    end else if (a == `A_VID) begin
      return {6'h00, s.vid};
    end else if (a == `A_TID) begin
      return {6'h00, s.tid};
    end else if (a == `A_ERR_A) begin
      return {12'h000, s.err};
    end else if (a == `A_DRSV_B) begin
      return `RST_DRSV_B;
    end
    return 16'h0000;
  endfunction : reg_rd

  logic                 sclk_rise;
  logic                 sclk_fall;
  logic                 ss_fall;
  logic                 ss_rise;
  logic [25:0]          nsh;
  logic [7:0]           need;
  logic                 narrow;
  logic signed [11:0]   corr;
  logic [9:0]           w;
  logic [16:0]          sum;
  logic [9:0]           cur;

  always_comb begin
    next_q    = q;
    sclk_rise = 1'b0;
    sclk_fall = 1'b0;
    ss_fall   = 1'b0;
    ss_rise   = 1'b0;
    nsh       = {q.sh[24:0], q.mosi_s[1]};
    need      = 8'h01 << q.blk[`F_SAMP_HI:`F_SAMP_LO];
    narrow    = q.gen[`F_NARROW];
    corr      = 12'sd0;
    w         = 10'h000;
    sum       = 17'h00000;
    cur       = 10'h000;

    // Only the second stage of each synchroniser is looked at
    next_q.sclk_s = {q.sclk_s[0], spi_sclk_i};
    next_q.ss_s   = {q.ss_s[0], spi_ss_n_i};
    next_q.mosi_s = {q.mosi_s[0], spi_mosi_i};
    next_q.sclk_p = q.sclk_s[1];
    next_q.ss_p   = q.ss_s[1];
    sclk_rise = q.sclk_s[1] & ~q.sclk_p;
    sclk_fall = ~q.sclk_s[1] & q.sclk_p;
    ss_fall   = ~q.ss_s[1] & q.ss_p;
    ss_rise   = q.ss_s[1] & ~q.ss_p;

    case (q.ph)
      SPI_IDLE: begin
        if (ss_fall) begin
          next_q.bcnt = 5'd0;
          next_q.ph   = SPI_SHIFT;
        end
      end
      SPI_SHIFT: begin
        if (ss_rise) begin
          next_q.ph = SPI_IDLE;
        end else if (sclk_rise) begin
          next_q.sh   = nsh;
          next_q.bcnt = q.bcnt + 5'd1;
          if (q.bcnt + 5'd1 == `SPI_HDR_BITS) begin
            next_q.rd = reg_rd(q, nsh[9:1]);
          end
          if (q.bcnt + 5'd1 == `SPI_ALL_BITS) begin
            next_q.ph = SPI_DONE;
          end
        end else if (sclk_fall && q.bcnt >= `SPI_HDR_BITS) begin
          next_q.miso = q.rd[15];
          next_q.rd   = {q.rd[14:0], 1'b0};
        end
      end
      SPI_DONE: begin
        if (sclk_fall) begin
          next_q.miso = 1'b0;
        end
        // A write only lands when a complete frame ends
        if (ss_rise) begin
          next_q.ph = SPI_IDLE;
          if (q.sh[16]) begin
            if (q.sh[25:17] == `A_PWR) begin
              next_q.pwr = q.sh[2:0];
            end else if (q.sh[25:17] == `A_BLK) begin
              next_q.blk = q.sh[15:0];
            end else if (q.sh[25:17] == `A_GEN) begin
              next_q.gen = q.sh[15:0];
            end else if (q.sh[25:17] == `A_TRAIN) begin
              next_q.train = q.sh[9:0];
            end else if (q.sh[25:17] == `A_SW0) begin
              next_q.sw0 = q.sh[15:0];
            end else if (q.sh[25:17] == `A_FSYNC) begin
              next_q.fsync = q.sh[6:0];
            end else if (q.sh[25:17] == `A_BID) begin
              next_q.bid = q.sh[9:0];
            end else if (q.sh[25:17] == `A_VID) begin
              next_q.vid = q.sh[9:0];
            end else if (q.sh[25:17] == `A_TID) begin
              next_q.tid = q.sh[9:0];
            end
          end
        end
      end
      default: begin
        next_q.ph = SPI_IDLE;
      end
    endcase

    for (int c = 0; c < NCH; c++) begin
      if (q.gen[`F_AUTO_CAL]) begin
        corr = {q.ofs[c][10], q.ofs[c]};
      end else if (q.gen[`F_OFS_DEC]) begin
        corr = -$signed({3'b000, q.gen[`F_OFS_HI:`F_OFS_LO]});
      end else begin
        corr = $signed({3'b000, q.gen[`F_OFS_HI:`F_OFS_LO]});
      end
      w = clamp($signed({2'b00, pix_i.pix[c]}) + corr);
      if (narrow) begin
        w = {2'b00, w[9:2]};
      end

      if (pix_i.sol) begin
        next_q.acc[c]   = 17'h00000;
        next_q.cnt[c]   = 8'h00;
        next_q.done[c]  = 1'b0;
        next_q.bline[c] = 1'b0;
        next_q.crc[c]   = q.blk[`F_CRC_SEED] ? 10'h3ff : 10'h000;
      end else begin
        if (pix_i.valid && pix_i.black && !q.done[c]) begin
          next_q.bline[c] = 1'b1;
          sum = q.acc[c] + {7'h00, pix_i.pix[c]};
          if (q.cnt[c] == need - 8'h01) begin
            sum = sum >> q.blk[`F_SAMP_HI:`F_SAMP_LO];
            next_q.ofs[c] = {3'b000, q.blk[`F_TGT_HI:0]}
                          - {1'b0, sum[9:0]};
            next_q.done[c] = 1'b1;
            next_q.acc[c]  = 17'h00000;
            next_q.cnt[c]  = 8'h00;
          end else begin
            next_q.acc[c] = sum;
            next_q.cnt[c] = q.cnt[c] + 8'h01;
          end
        end
        if (pix_i.valid) begin
          next_q.crc[c] = crc_step(q.crc[c], w);
        end
        // A short black run leaves the flag up until a later line completes
        if (pix_i.eol && q.bline[c]) begin
          next_q.err[c] = ~q.done[c];
        end
      end

      if (!q.pwr[`F_DATA_PWD_N]) begin
        next_q.out.data[c] = 10'h000;
      end else if (pix_i.valid) begin
        next_q.out.data[c] = w;
      end else if (pix_i.eol) begin
        next_q.out.data[c] = q.crc[c];
      end else begin
        next_q.out.data[c] = q.train;
      end
    end

    if (pix_i.sol) begin
      cur = {pix_i.sof, 2'b10, q.fsync};
    end else if (pix_i.eol) begin
      cur = {pix_i.eof, 2'b01, q.fsync};
    end else if (pix_i.valid) begin
      cur = pix_i.black ? q.bid : q.vid;
    end else begin
      cur = q.tid;
    end
    next_q.dl = {q.dl[2:0], cur};
    if (!q.pwr[`F_SYNC_PWD_N]) begin
      next_q.out.sync = 10'h000;
    end else if (narrow) begin
      next_q.out.sync = q.dl[`NARROW_DELAY-1];
    end else begin
      next_q.out.sync = cur;
    end
    next_q.en = q.pwr;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q        <= '0;
      q.ss_s   <= 2'b11;
      q.ss_p   <= 1'b1;
      q.ph     <= SPI_IDLE;
      q.pwr    <= `RST_PWR;
      q.blk    <= `RST_BLK;
      q.gen    <= `RST_GEN;
      q.sw0    <= `RST_SW0;
      q.train  <= `RST_TRAIN;
      q.fsync  <= `RST_FSYNC;
      q.bid    <= `RST_BID;
      q.vid    <= `RST_VID;
      q.tid    <= `RST_TID;
    end else begin
      q <= next_q;
    end
  end

  assign spi_miso_o     = q.miso;
  assign lanes_o        = q.out;
  assign clk_lane_en_o  = q.en[`F_CLK_PWD_N];
  assign sync_lane_en_o = q.en[`F_SYNC_PWD_N];
  assign data_lane_en_o = q.en[`F_DATA_PWD_N];

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  AST_PWR: assert property (!q.pwr[2] |=> lanes_o.data == '0)
    else $error("data lanes live while powered down");
  AST_IDLE: assert property (q.pwr[2] && !pix_i.valid
    && !pix_i.eol |=> lanes_o.data[0] == $past(q.train))
    else $error("idle lane lacks training word");
  AST_TID: assert property (q.pwr[1] && !narrow && !pix_i.valid
    && !pix_i.sol && !pix_i.eol |=> lanes_o.sync == $past(q.tid))
    else $error("training id missing");
  AST_VID: assert property (q.pwr[1] && !narrow && pix_i.valid
    && !pix_i.black && !pix_i.sol && !pix_i.eol
    |=> lanes_o.sync == $past(q.vid))
    else $error("valid id missing");
  AST_BID: assert property (q.pwr[1] && !narrow && pix_i.valid
    && pix_i.black && !pix_i.sol && !pix_i.eol
    |=> lanes_o.sync == $past(q.bid))
    else $error("black id missing");
  AST_FSYNC: assert property (q.pwr[1] && pix_i.sof && pix_i.sol
    && !narrow |=> lanes_o.sync == {3'b110, $past(q.fsync)})
    else $error("frame start word wrong");
  AST_NARROW: assert property (q.pwr[1] && narrow && pix_i.sof
    && pix_i.sol |-> ##5 (!narrow || !q.pwr[1]
    || lanes_o.sync == {3'b110, $past(q.fsync, 5)}))
    else $error("narrow sync not delayed by four");
  // Below 0x200 the sum with any offset stays under the clamp
  AST_MANUAL: assert property (q.pwr[2] && !narrow && !q.gen[0]
    && !q.gen[10] && pix_i.valid && pix_i.pix[0] < 10'h200
    |=> lanes_o.data[0] == $past(pix_i.pix[0])
    + {1'b0, $past(q.gen[9:1])})
    else $error("manual offset not added");
  AST_SEED: assert property (pix_i.sol |=> q.crc[0] ==
    ($past(q.blk[15]) ? 10'h3ff : 10'h000))
    else $error("crc seed wrong");
  AST_ERR: assert property (pix_i.eol && !pix_i.sol && q.bline[0]
    && !q.done[0] |=> q.err[0])
    else $error("calibration fault flag not set");
  AST_SAMP: assert property (pix_i.valid && pix_i.black
    && !pix_i.sol && !q.done[0] && q.cnt[0] == need - 8'h01
    |=> q.done[0])
    else $error("sample count wrong");

  COV_FRAME: cover property (pix_i.sof && pix_i.sol ##1 pix_i.valid);
  COV_ERR: cover property ($rose(q.err[0]));
  COV_WRITE: cover property (q.ph == SPI_DONE && ss_rise && q.sh[16]);

endmodule : sensor_output_sync_framing

/* tb/lane_receiver.sv */
`timescale 1ns/100ps
module lane_receiver
  import sensor_output_sync_framing_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire lanes_t     lanes_i,
  input  wire logic [9:0] train_i,
  output logic            aligned_o
);
  logic [NCH-1:0][2:0] run;

  // Lock needs a run of training words so one pixel equal to the
  // pattern cannot fake word alignment
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      run <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (lanes_i.data[i] !== train_i) begin
          run[i] <= 3'h0;
        end else if (run[i] != 3'h7) begin
          run[i] <= run[i] + 3'h1;
        end
      end
    end
  end

  always_comb begin
    aligned_o = 1'b1;
    for (int i = 0; i < NCH; i++) begin
      aligned_o = aligned_o & (run[i] >= 3'h4);
    end
  end
endmodule : lane_receiver

/* tb/sensor_output_sync_framing_tb_top.sv */
`timescale 1ns/100ps
`include "sensor_output_sync_framing_defs.svh"
module sensor_output_sync_framing_tb_top
  import sensor_output_sync_framing_pkg::*;
();
  localparam logic [5:0] pv = 6'h20, pb = 6'h10, psof = 6'h08;
  localparam logic [5:0] psol = 6'h04, peof = 6'h02, peol = 6'h01;
  logic       sys_clk = 1'b0;
  logic       rst, sclk, ss_n, mosi, miso;
  logic       clk_en, sync_en, data_en, aligned;
  logic [9:0] train_word;
  pix_in_t    pix;
  lanes_t     lanes;
  int         err_count, cmp_count, cyc;
  logic [8:0]  ra [18] = '{9'h050, 9'h051, 9'h060, 9'h061, 9'h070,
    9'h080, 9'h081, 9'h082, 9'h083, 9'h084, 9'h085, 9'h086, 9'h087,
    9'h088, 9'h08b, 9'h08c, 9'h08d, 9'h1ff};
  logic [15:0] rv [18] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h4008, 16'hc001, 16'h03a6, 16'h002a, 16'h002a,
    16'h0035, 16'h0059, 16'h03a6, 16'h0000, 16'h0000, 16'h0000,
    16'hffff, 16'h0000};

  sensor_output_sync_framing sensor_output_sync_framing_inst (
    .sys_clk_i      (sys_clk),
    .rst_i          (rst),
    .spi_sclk_i     (sclk),
    .spi_ss_n_i     (ss_n),
    .spi_mosi_i     (mosi),
    .spi_miso_o     (miso),
    .pix_i          (pix),
    .lanes_o        (lanes),
    .clk_lane_en_o  (clk_en),
    .sync_lane_en_o (sync_en),
    .data_lane_en_o (data_en)
  );

  lane_receiver lane_receiver_inst (
    .sys_clk_i (sys_clk),
    .rst_i     (rst),
    .lanes_i   (lanes),
    .train_i   (train_word),
    .aligned_o (aligned)
  );

  always #50 sys_clk = ~sys_clk;

  task automatic tally_and_finish();
    $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      tally_and_finish();
    end
  end

  task automatic chk(input string nm, input logic [39:0] seen,
                     input logic [39:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Low phase 500 ns leaves the synchronised read bit time to settle
  task automatic spi(input logic [8:0] a, input logic w,
                     input logic [15:0] d, output logic [15:0] q);
    logic [25:0] f;
    f = {a, w, d};
    q = '0;
    @(negedge sys_clk);
    ss_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    for (int i = 25; i >= 0; i--) begin
      mosi = f[i];
      repeat (5) @(negedge sys_clk);
      if (i < 16) q[i] = miso;
      sclk = 1'b1;
      repeat (3) @(negedge sys_clk);
      sclk = 1'b0;
    end
    repeat (4) @(negedge sys_clk);
    ss_n = 1'b1;
    repeat (10) @(negedge sys_clk);
  endtask : spi

  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    logic [15:0] q;
    spi(a, 1'b1, d, q);
  endtask : wr

  task automatic rd(input logic [8:0] a, output logic [15:0] q);
    spi(a, 1'b0, 16'h0000, q);
  endtask : rd

  // One word on the pixel port; returns when its output is on the lanes
  task automatic px(input logic [5:0] f, input logic [9:0] v);
    @(negedge sys_clk);
    {pix.valid, pix.black, pix.sof, pix.sol, pix.eof, pix.eol} = f;
    pix.pix = {NCH{v}};
    @(negedge sys_clk);
    pix = '0;
  endtask : px

  initial begin
    logic [15:0] q;
    rst = 1'b1;
    sclk = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b0;
    pix = '0;
    train_word = 10'h3a6;
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk("lane enables", {clk_en, sync_en, data_en}, 3'h0);
    chk("data off", lanes.data, 40'h0);
    for (int i = 0; i < 18; i++) begin
      rd(ra[i], q);
      chk("reset value", q, rv[i]);
    end
    wr(`A_ERR_A, 16'hffff);
    rd(`A_ERR_A, q);
    chk("fault read only", q, 16'h0000);
    for (int i = 1; i < 8; i++) begin
      wr(`A_PWR, 16'(i));
      repeat (2) @(negedge sys_clk);
      chk("lane enables", {data_en, sync_en, clk_en}, i[2:0]);
    end
    px(6'h00, 10'h000);
    chk("idle data", lanes.data, {NCH{10'h3a6}});
    chk("idle sync", lanes.sync, 10'h3a6);
    wr(`A_TRAIN, 16'h0155);
    train_word = 10'h155;
    wr(`A_TID, 16'h02aa);
    px(6'h00, 10'h000);
    chk("train data", lanes.data, {NCH{10'h155}});
    chk("train sync", lanes.sync, 10'h2aa);
    chk("receiver lock", aligned, 1'b1);
    // Only the seven low bits of the frame marker are programmable
    wr(`A_FSYNC, 16'h00d5);
    px(psof | psol, 10'h000);
    chk("frame start", lanes.sync, 10'h355);
    px(psol, 10'h000);
    chk("line start", lanes.sync, 10'h155);
    px(peol, 10'h000);
    chk("line end", lanes.sync, 10'h0d5);
    chk("crc zero seed", lanes.data, 40'h0);
    px(peof | peol, 10'h000);
    chk("frame end", lanes.sync, 10'h2d5);
    // Two samples of 0x20 and 0x22 average to 0x21 against target 0x10
    wr(`A_BLK, 16'h0110);
    px(psol, 10'h000);
    px(pv | pb, 10'h020);
    chk("black id", lanes.sync, 10'h035);
    px(pv | pb, 10'h022);
    px(pv, 10'h100);
    chk("auto cal", lanes.data, {NCH{10'h0ef}});
    chk("valid id", lanes.sync, 10'h059);
    px(peol, 10'h000);
    rd(`A_ERR_A, q);
    chk("fault clear", q, 16'h0000);
    wr(`A_BLK, 16'h0210);
    px(psol, 10'h000);
    px(pv | pb, 10'h020);
    px(peol, 10'h000);
    rd(`A_ERR_A, q);
    chk("fault set", q, 16'h000f);
    wr(`A_BLK, 16'h8110);
    px(psol, 10'h000);
    px(peol, 10'h000);
    chk("crc one seed", lanes.data, {NCH{10'h3ff}});
    wr(`A_GEN, 16'hc00a);
    px(pv, 10'h100);
    chk("manual add", lanes.data, {NCH{10'h105}});
    wr(`A_GEN, 16'hc40a);
    px(pv, 10'h100);
    chk("manual sub", lanes.data, {NCH{10'h0fb}});
    wr(`A_GEN, 16'he000);
    px(pv, 10'h3fc);
    chk("narrow data", lanes.data, {NCH{10'h0ff}});
    chk("narrow early", lanes.sync, 10'h2aa);
    repeat (4) @(negedge sys_clk);
    chk("narrow late", lanes.sync, 10'h059);
    px(psof | psol, 10'h000);
    repeat (4) @(negedge sys_clk);
    chk("narrow frame", lanes.sync, 10'h355);
    wr(`A_PWR, 16'h0000);
    px(pv, 10'h100);
    chk("data off", lanes.data, 40'h0);
    tally_and_finish();
  end
endmodule : sensor_output_sync_framing_tb_top
